// [hdl/avg_cfg.svh]
`ifndef AVG_CFG_SVH
`define AVG_CFG_SVH

`define AVG_WORD_W      32
`define AVG_ACC_W       64
`define AVG_N_W         24
`define AVG_EDGE_W      5
`define AVG_MAX_SHIFT   14
`define AVG_SHIFT_W     4
`define AVG_TERM_EDGES  5'h14
`define AVG_COUNT_W     14
`define AVG_COUNT_SAT   14'h3FFF
`define AVG_N_MAX       24'h004000
`define AVG_N_ONE       24'h000001
`define AVG_CFG_W       8
`define AVG_CFG_WORD    8'h5A
`define AVG_OUT_W       54
`define AVG_POS_FULL    32'h7FFFFFFF
`define AVG_NEG_FULL    32'h80000000

`endif

// [hdl/avg_pkg.sv]
`include "avg_cfg.svh"

package avg_pkg;

    typedef logic [`AVG_WORD_W-1:0] word_t;

    typedef struct packed {
        logic [1:0][`AVG_WORD_W-1:0] mem;
        logic                        wr_ptr;
        logic                        rd_ptr;
        logic [1:0]                  count;
    } buf_state_s;

    typedef struct packed {
        logic                        start_meta;
        logic                        start_sync;
        logic                        start_prev;
        logic                        sck_meta;
        logic                        sck_sync;
        logic                        sck_prev;
        logic                        busy;
        logic                        reading;
        logic                        load;
        logic [`AVG_EDGE_W-1:0]      edge_cnt;
        logic [`AVG_ACC_W-1:0]       acc;
        logic [`AVG_N_W-1:0]         n;
        logic [`AVG_WORD_W-1:0]      result;
        logic [`AVG_WORD_W-1:0]      filtered;
        logic [`AVG_OUT_W-1:0]       shreg;
    } filt_state_s;

endpackage : avg_pkg

// [hdl/two_entry_buffer.sv]
`timescale 1ns/1ns
`include "avg_cfg.svh"

module two_entry_buffer
    import avg_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  in_valid_i,
    output logic       in_ready_o,
    input  wire word_t in_data_i,
    output logic       out_valid_o,
    input  wire logic  out_ready_i,
    output word_t      out_data_o
);

    buf_state_s st;
    buf_state_s next_st;
    logic       push;
    logic       pop;

    assign in_ready_o  = (st.count != 2'h2);
    assign out_valid_o = (st.count != 2'h0);
    assign out_data_o  = st.mem[st.rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.mem[st.wr_ptr] = in_data_i;
            next_st.wr_ptr         = ~st.wr_ptr;
        end
        if (pop)
        begin
            next_st.rd_ptr = ~st.rd_ptr;
        end
        if (push && !pop)
        begin
            next_st.count = st.count + 2'h1;
        end
        else if (pop && !push)
        begin
            next_st.count = st.count - 2'h1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule : two_entry_buffer

// [hdl/averaging_decimator.sv]
// Contract
// - block of one: each cycle's newest result lands in the filtered register.
// - ready strobe marks each result update and equals converter busy.
// - results keep accumulating until a read; a read restarts the average.
// - any block size 1 to 16384, set only by read initiation rate.
// - output is sum divided by smallest power of two not below N.
// - non power of two N stays scaled by N/M, uncorrected.
// - divisor stops at 16384; accumulation continues, output saturates at full scale.
// - cycle with 1 to 19 shift edges leaves filtered register unchanged.
// - first shift edge after a terminated read starts a read, resets filter.
// - cycle with 0 or over 19 edges terminates read, resumes updates.
// - average covers conversions completed between two read initiations.
// - zero-edge cycle terminates read at its conversion completion, then updates.
// - 14-bit count field is samples minus one, saturating at 16383.
// - result register holds newest 32-bit result, sampled when taken from the buffer.
`timescale 1ns/1ns
`include "avg_cfg.svh"

module averaging_decimator
    import avg_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  conv_start_i,
    input  wire logic  conv_valid_i,
    output logic       conv_ready_o,
    input  wire word_t conv_data_i,
    input  wire logic  filtered_shift_clock_i,
    output logic       filtered_serial_out_o,
    output logic       filter_ready_strobe_o
);

    filt_state_s                       st;
    filt_state_s                       next_st;
    logic                              drain_valid;
    logic                              drain_ready;
    word_t                             drain_data;
    logic                              start_rise;
    logic                              sck_rise;
    logic                              pop;
    logic                              term;
    logic                              partial;
    logic                              pos_over;
    logic signed [`AVG_ACC_W-1:0]      acc_new;
    logic [`AVG_N_W-1:0]               n_new;
    logic [`AVG_SHIFT_W-1:0]           shift_c;
    logic signed [`AVG_ACC_W-1:0]      scaled_c;
    word_t                             avg_c;
    logic [`AVG_COUNT_W-1:0]           count_c;
    logic [`AVG_N_W-1:0]               n_less;

    localparam logic signed [`AVG_ACC_W-1:0] POS_LIM =
        `AVG_ACC_W'($signed(`AVG_POS_FULL));
    localparam logic signed [`AVG_ACC_W-1:0] NEG_LIM =
        `AVG_ACC_W'($signed(`AVG_NEG_FULL));

    // results from the core wait here while the filter stalls
    two_entry_buffer u_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (conv_valid_i),
        .in_ready_o  (conv_ready_o),
        .in_data_i   (conv_data_i),
        .out_valid_o (drain_valid),
        .out_ready_i (drain_ready),
        .out_data_o  (drain_data)
    );

    assign drain_ready           = ~st.load;
    assign start_rise            = st.start_sync & ~st.start_prev;
    assign sck_rise              = st.sck_sync & ~st.sck_prev;
    assign pop                   = drain_valid & drain_ready;
    assign term                  = (st.edge_cnt == '0) || (st.edge_cnt >= `AVG_TERM_EDGES);
    assign partial               = ~term;
    assign filter_ready_strobe_o = st.busy;
    assign filtered_serial_out_o = st.shreg[`AVG_OUT_W-1];

    // running sum including the result being taken now
    always_comb
    begin
        acc_new = $signed(st.acc) + `AVG_ACC_W'($signed(drain_data));
        n_new   = (st.n == '1) ? st.n : st.n + `AVG_N_ONE;
    end

    // divisor exponent: smallest power of two not below n, capped
    always_comb
    begin
        shift_c = '0;
        for (int i = 0; i < `AVG_MAX_SHIFT; i++)
        begin
            if (n_new > (`AVG_N_ONE << i))
            begin
                shift_c = `AVG_SHIFT_W'(i + 1);
            end
        end
        scaled_c = acc_new >>> shift_c;
        pos_over = scaled_c > POS_LIM;
        if (pos_over)
        begin
            avg_c = `AVG_POS_FULL;
        end
        else if (scaled_c < NEG_LIM)
        begin
            avg_c = `AVG_NEG_FULL;
        end
        else
        begin
            avg_c = scaled_c[`AVG_WORD_W-1:0];
        end
        n_less = n_new - `AVG_N_ONE;
        if (n_new > `AVG_N_MAX)
        begin
            count_c = `AVG_COUNT_SAT;
        end
        else
        begin
            count_c = n_less[`AVG_COUNT_W-1:0];
        end
    end

    always_comb
    begin
        logic reading_now;
        logic reloaded;
        reading_now        = st.reading;
        reloaded           = 1'b0;
        next_st            = st;
        next_st.start_meta = conv_start_i;
        next_st.start_sync = st.start_meta;
        next_st.start_prev = st.start_sync;
        next_st.sck_meta   = filtered_shift_clock_i;
        next_st.sck_sync   = st.sck_meta;
        next_st.sck_prev   = st.sck_sync;
        next_st.load       = 1'b0;
        if (start_rise)
        begin
            next_st.busy = 1'b1;
        end
        if (pop)
        begin
            next_st.busy     = 1'b0;
            next_st.result   = drain_data;
            next_st.acc      = acc_new;
            next_st.n        = n_new;
            next_st.edge_cnt = '0;
            if (term)
            begin
                // read over: newest average into the filtered register
                next_st.reading  = 1'b0;
                next_st.load     = 1'b1;
                next_st.filtered = avg_c;
                next_st.shreg    = {avg_c, `AVG_CFG_WORD, count_c};
                reading_now      = 1'b0;
                reloaded         = 1'b1;
            end
        end
        if (sck_rise)
        begin
            if (next_st.edge_cnt < `AVG_TERM_EDGES)
            begin
                next_st.edge_cnt = next_st.edge_cnt + `AVG_EDGE_W'(1);
            end
            if (!reloaded)
            begin
                next_st.shreg = {st.shreg[`AVG_OUT_W-2:0], 1'b0};
            end
            if (!reading_now)
            begin
                // new read: averaging restarts after this point
                next_st.reading = 1'b1;
                next_st.acc     = '0;
                next_st.n       = '0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_strobe_rise: assert property (
        start_rise && !pop |=> filter_ready_strobe_o)
        else $error("strobe did not rise at conversion start");

    a_strobe_fall: assert property (
        pop && !start_rise |=> !filter_ready_strobe_o)
        else $error("strobe did not fall at result update");

    a_single_load: assert property (
        pop && term && st.n == '0 |=> st.filtered == $past(drain_data) && st.load)
        else $error("single result not loaded");

    a_hold_partial: assert property (
        pop && partial |=> $stable(st.filtered) && !st.load)
        else $error("filtered register changed mid read");

    a_term_update: assert property (
        pop && term |=> st.load && st.filtered == $past(avg_c))
        else $error("terminated read did not update output");

    a_init_reset: assert property (
        sck_rise && !st.reading && !pop |=> st.reading && st.acc == '0 && st.n == '0)
        else $error("read initiation did not reset filter");

    a_accumulate: assert property (
        pop && !sck_rise && st.n < `AVG_N_MAX |=> st.n == $past(st.n) + `AVG_N_ONE)
        else $error("conversion not accumulated");

    a_count_sat: assert property (
        pop && term && st.n >= `AVG_N_MAX |=> st.shreg[`AVG_COUNT_W-1:0] == `AVG_COUNT_SAT)
        else $error("count field not saturated");

    a_clamp_pos: assert property (
        pop && term && pos_over |=> st.filtered == `AVG_POS_FULL)
        else $error("output not clamped to positive full scale");

    a_edge_count: assert property (
        sck_rise && !pop && st.edge_cnt < `AVG_TERM_EDGES
        |=> st.edge_cnt == $past(st.edge_cnt) + `AVG_EDGE_W'(1))
        else $error("shift edge not counted");

    a_serial_shift: assert property (
        sck_rise && !(pop && term) |=> filtered_serial_out_o == $past(st.shreg[`AVG_OUT_W-2]))
        else $error("serial output did not advance");

    a_result_reg: assert property (
        pop |=> st.result == $past(drain_data))
        else $error("result register missed newest result");

    c_single: cover property (pop && term && st.n == '0);
    c_partial: cover property (pop && partial ##[1:300] pop && term);
    c_stall: cover property (drain_valid && !drain_ready && !conv_ready_o);
    c_saturate: cover property (pop && term && pos_over);

endmodule : averaging_decimator

// [testbench/shift_host.sv]
`timescale 1ns/1ns

module shift_host
(
    input  wire logic sdo_i,
    output logic      sck_o
);
    logic [53:0] word;

    initial
    begin
        sck_o = 1'b0;
        word  = 54'h0;
    end

    // n edges at 125 ns; clock idles low between bursts
    task burst(input int n);
        for (int i = 0; i < n; i++)
        begin
            word  = {word[52:0], sdo_i};
            sck_o = 1'b1;
            #62;
            sck_o = 1'b0;
            #63;
        end
    endtask : burst
endmodule : shift_host

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`include "avg_cfg.svh"

module tb_top
    import avg_pkg::*;
;
    logic  clk_i   = 1'b0;
    logic  rst_i   = 1'b1;
    logic  start   = 1'b0;
    logic  valid   = 1'b0;
    word_t data    = 32'h0;
    logic  full    = 1'b0;
    logic  ready;
    logic  sdo;
    logic  strobe;
    logic  sck;
    int    n_errors = 0;
    int    checked  = 0;
    int    e [4]    = '{32, 20, 32, 20};
    int    d [4]    = '{12, 12, 12, 18};
    word_t x [5]    = '{32'hA5C30F17, 32'h80000001, 32'h7FFFFFFE, 32'h12345678, 32'hFEDCBA98};

    always #2 clk_i = ~clk_i;

    averaging_decimator uut
    (
        .clk_i                  (clk_i),
        .rst_i                  (rst_i),
        .conv_start_i           (start),
        .conv_valid_i           (valid),
        .conv_ready_o           (ready),
        .conv_data_i            (data),
        .filtered_shift_clock_i (sck),
        .filtered_serial_out_o  (sdo),
        .filter_ready_strobe_o  (strobe)
    );

    shift_host host
    (
        .sdo_i (sdo),
        .sck_o (sck)
    );

    task check(input logic [53:0] s, input logic [53:0] x_exp);
        checked++;
        if (s !== x_exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x_exp);
        end
    endtask : check

    task summarize;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    // expected average: shift by log2 of next power of two, capped, clamped
    function automatic word_t mean(input longint s, input int n);
        int     k;
        longint q;
        k = 0;
        while (k < 14 && (1 << k) < n)
            k++;
        q = s >>> k;
        if (q > 64'sh7FFFFFFF)
            return 32'h7FFFFFFF;
        if (q < -64'sh80000000)
            return 32'h80000000;
        return q[31:0];
    endfunction : mean

    task push(input word_t v, input int n);
        int k;
        k = 0;
        @(posedge clk_i);
        valid <= 1'b1;
        data  <= v;
        while (k < n)
        begin
            @(posedge clk_i);
            if (ready === 1'b1)
                k++;
            else
                full = 1'b1;
        end
        valid <= 1'b0;
    endtask : push

    task until_strobe(input logic lvl);
        for (int i = 0; i < 20 && strobe !== lvl; i++)
            @(posedge clk_i);
    endtask : until_strobe

    task conv(input word_t v);
        @(posedge clk_i);
        start <= 1'b1;
        until_strobe(1'b1);
        check(strobe, 1'b1);
        start <= 1'b0;
        push(v, 1);
        until_strobe(1'b0);
        check(strobe, 1'b0);
        repeat (4) @(posedge clk_i);
    endtask : conv

    task rd54(input word_t a, input logic [13:0] c);
        host.burst(54);
        check(host.word[53:22], a);
        check(host.word[21:14], `AVG_CFG_WORD);
        check(host.word[13:0], c);
    endtask : rd54

    task t_single;
        conv(x[0]);
        for (int i = 0; i < 4; i++)
        begin
            host.burst(e[i]);
            if (e[i] == 32)
                check(host.word[31:0], x[i]);
            else
                check(host.word[19:0], x[i][31:12]);
            conv(x[i + 1]);
        end
        $display("test single done");
    endtask : t_single

    task t_three;
        host.burst(32);
        check(host.word[31:0], x[4]);
        conv(32'hFFFFFFF8);
        conv(32'hFFFFFFF4);
        conv(32'hFFFFFFF0);
        rd54(mean(-64'sh24, 3), 14'h2);
        $display("test three done");
    endtask : t_three

    task t_distrib;
        conv(32'h00001234);
        for (int i = 0; i < 4; i++)
        begin
            host.burst(d[i]);
            conv(32'h00000100);
        end
        check(host.word, {32'h00001234, `AVG_CFG_WORD, 14'h0});
        conv(32'h00000100);
        rd54(mean(64'sh500, 5), 14'h4);
        $display("test distributed done");
    endtask : t_distrib

    task t_saturate;
        push(32'h7FFFFFFF, 16386);
        repeat (8) @(posedge clk_i);
        check(full, 1'b1);
        rd54(mean(64'sh7FFFFFFF * 16386, 16386), 14'h3FFF);
        $display("test saturate done");
    endtask : t_saturate

    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_single();
        t_three();
        t_distrib();
        t_saturate();
        summarize();
    end

    initial
    begin
        #300000;
        n_errors++;
        summarize();
    end
endmodule : tb_top
